// file: nirqc_chk.sv
// port checker of the normal request controller
// bound into nirqc_top; one clock, sync reset
`timescale 1ns/10ps
`include "nirqc_defines.vh"
module nirqc_chk #(parameter ADDR_W = 32, DATA_W = 32, SRC_W = 18) (
	input wire logic              i_sys_clk, i_rst, i_wr, i_rd, o_irq, o_fiq, o_wake,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata, o_rdata,
	input wire logic [SRC_W-1:0]  i_src_req
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	property p_idle; !$past(i_rd) |-> o_rdata == 0; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_rst; $past(i_rst) |-> !(o_irq || o_fiq || o_wake); endproperty
	a_rst: assert property (p_rst) else $error("request after reset");
	property p_top; $past(i_rd) |-> o_rdata[31:20] == 0; endproperty
	a_top: assert property (p_top) else $error("upper bits set");
	property p_b15; $past(i_rd) |-> !o_rdata[15]; endproperty
	a_b15: assert property (p_b15) else $error("reserved bit set");
	property p_b0; $past(i_rd) |-> !o_rdata[0]; endproperty
	a_b0: assert property (p_b0) else $error("bit zero set");
	property p_wake; o_wake == (o_irq || o_fiq); endproperty
	a_wake: assert property (p_wake) else $error("wake mismatch");
	property p_clr; $past(i_rd) && $past(i_addr) == `NIRQC_OFS_ENABLE_CLEAR |-> o_rdata == 0; endproperty
	a_clr: assert property (p_clr) else $error("clear readable");
	property p_msk; $past(i_rd) && $past(i_addr) == `NIRQC_OFS_ENABLE_MASK |-> !o_rdata[1]; endproperty
	a_msk: assert property (p_msk) else $error("mask bit one set");
	c_irq: cover property (o_irq);
	c_fiq: cover property (o_fiq);
	c_clr: cover property (i_wr && i_addr == `NIRQC_OFS_ENABLE_CLEAR);
endmodule // nirqc_chk
bind nirqc_top nirqc_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .SRC_W(SRC_W)) chk_u (.i_sys_clk, .i_rst, .i_wr,
	.i_rd, .o_irq, .o_fiq, .o_wake, .i_addr, .i_wdata, .o_rdata, .i_src_req);

// file: nirqc_defines.vh
// register offsets, field positions and reset values of the normal interrupt request controller
// assumes a 32-bit register port with byte addresses
`ifndef NIRQC_DEFINES_VH
`define NIRQC_DEFINES_VH
`define NIRQC_ADDR_W              32
`define NIRQC_DATA_W              32
`define NIRQC_OFS_PENDING_STATUS  32'hffff0000
`define NIRQC_OFS_SOURCE_LEVEL    32'hffff0004
`define NIRQC_OFS_ENABLE_MASK     32'hffff0008
`define NIRQC_OFS_ENABLE_CLEAR    32'hffff000c
`define NIRQC_OFS_FAST_ENABLE     32'hffff0108
`define NIRQC_OFS_FAST_CLEAR      32'hffff010c
`define NIRQC_OFS_SOFT_CONFIG     32'hffff0110
`define NIRQC_BIT_FAST_OR         0
`define NIRQC_BIT_SOFT            1
`define NIRQC_SRC_LO              2
`define NIRQC_SRC_HI              19
`define NIRQC_BIT_RESERVED        15
`define NIRQC_SRC_W               18
`define NIRQC_MASKABLE            32'h000f7ffc
`define NIRQC_RESET_VALUE         32'h00000000
`endif

// file: nirqc_periph.sv
// peripheral request model: each flag is its raise bit registered one clock later, with no holding
// driven by the bench raise vector
`timescale 1ns/10ps
module nirqc_periph (
	input  wire logic        i_sys_clk,
	input  wire logic [17:0] i_raise,
	output logic      [17:0] o_src_req
);
	always @(posedge i_sys_clk) begin
		o_src_req <= i_raise;
	end
endmodule // nirqc_periph

// file: nirqc_sync.v
// three flop synchroniser bank with agreement filter for peripheral request levels
// assumes asynchronous request inputs; output changes once stages two and three agree
`timescale 1ns/10ps
`include "nirqc_defines.vh"
module nirqc_sync #(
	parameter WIDTH = `NIRQC_SRC_W
) (
	// clock and reset
	input  wire             i_sys_clk,
	input  wire             i_rst,
	// levels
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_level
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			always @(posedge i_sys_clk) begin
				if (i_rst) begin
					stage1[g]  <= 1'b0;
					stage2[g]  <= 1'b0;
					stage3[g]  <= 1'b0;
					o_level[g] <= 1'b0;
				end else begin
					stage1[g] <= i_async[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
					if (stage2[g] == stage3[g]) begin
						o_level[g] <= stage3[g];
					end
				end
			end
		end
	endgenerate
endmodule // nirqc_sync

// file: nirqc_top.v
// normal interrupt request controller: source levels, mask, pending status, request line
// assumes a single-cycle register port; fast-side enable mask also gates the fast request line
// What this block does
// RULE1: seventeen peripheral sources accepted, each one masked on its own bit.
// RULE2: source level register shows live request levels, never latched.
// RULE3: pending status equals source level AND enable mask, except bit one, which follows soft_normal unmasked.
// RULE4: all pending bits ORed into one request line to the core.
// RULE5: no priority encoding or vector; software reads status to order sources.
// RULE6: enable mask writes set bits written one; reads return the mask.
// RULE7: enable clear writes clear mask bits written one; write only.
// RULE8: bit zero fast OR exists only on fast side, not normal registers.
// RULE9: bit one is software interrupt, ignored by mask and clear writes.
// RULE10: bits two to nine are timers, LIN, flash, PLL lock.
// RULE11: bits ten to nineteen are ADC, UART, SPI, pins, high voltage; fifteen reserved.
// RULE12: an unmasked-off source shows level but no status and no request.
// RULE13: software should capture pending status at handler entry.
// RULE14: core recognition masking never gates controller flags or the wake request.
// RULE15: setting a normal mask bit clears the fast one, and vice versa.
// RULE16: software config normal bit drives bit one of level and status together.
// RULE17: OR of fast pending drives the fast request line.
// RULE18: bits twenty to thirty-one read zero and ignore writes.
// RULE19: all registers reset to zero; no request after reset.
`timescale 1ns/10ps
`include "nirqc_defines.vh"
module nirqc_top #(
	parameter ADDR_W = `NIRQC_ADDR_W,
	parameter DATA_W = `NIRQC_DATA_W,
	parameter SRC_W  = `NIRQC_SRC_W
) (
	// clock and reset
	input  wire              i_sys_clk,
	input  wire              i_rst,
	// register port
	input  wire [ADDR_W-1:0] i_addr,
	input  wire [DATA_W-1:0] i_wdata,
	input  wire              i_wr,
	input  wire              i_rd,
	output reg  [DATA_W-1:0] o_rdata,
	// peripheral request levels, bit 0 = source bit 2
	input  wire [SRC_W-1:0]  i_src_req,
	// requests to the core
	output reg               o_irq,
	output reg               o_fiq,
	// wake request to the peripherals
	output reg               o_wake
);
	reg  [DATA_W-1:0] enable_mask;
	reg  [DATA_W-1:0] fast_enable_mask;
	reg               soft_normal;
	reg               soft_fast;
	wire [SRC_W-1:0]  src_sync;
	wire [DATA_W-1:0] src_bits;
	wire [DATA_W-1:0] source_level;
	wire [DATA_W-1:0] pending_status;
	wire [DATA_W-1:0] fast_level;
	wire [DATA_W-1:0] fast_pending;
	wire              fast_or;
	reg  [DATA_W-1:0] next_rdata;
	reg  [DATA_W-1:0] next_mask;
	reg  [DATA_W-1:0] next_fast_mask;
	wire [DATA_W-1:0] wmask;

	// address match, used by every write and read decode
	function hit;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	nirqc_sync #(
		.WIDTH(SRC_W)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst    (i_rst),
		.i_async  (i_src_req),
		.o_level  (src_sync)
	);

	// live levels, no latching; reserved bit 15 and top bits forced to zero
	assign src_bits = {{(DATA_W-`NIRQC_SRC_HI-1){1'b0}}, src_sync, 2'b00} & `NIRQC_MASKABLE; // [RULE1] [RULE2] [RULE10] [RULE11] [RULE18]
	assign fast_level = src_bits | {{(DATA_W-2){1'b0}}, soft_fast, 1'b0};
	assign fast_pending = fast_level & fast_enable_mask;
	assign fast_or = |fast_pending; // [RULE17]
	// bit 0 stays zero here; the fast OR drives only o_fiq and o_wake
	assign source_level = src_bits | {{(DATA_W-2){1'b0}}, soft_normal, 1'b0}; // [RULE8] [RULE16]
	assign pending_status = (source_level & enable_mask) | {{(DATA_W-2){1'b0}}, soft_normal, 1'b0}; // [RULE3] [RULE12] [RULE16]
	assign wmask = i_wdata & `NIRQC_MASKABLE; // [RULE9] [RULE18]

	always @* begin
		next_mask = enable_mask;
		next_fast_mask = fast_enable_mask;
		if (i_wr && hit(i_addr, `NIRQC_OFS_ENABLE_MASK)) begin
			next_mask = enable_mask | wmask; // [RULE6]
			next_fast_mask = fast_enable_mask & ~wmask; // [RULE15]
		end else if (i_wr && hit(i_addr, `NIRQC_OFS_ENABLE_CLEAR)) begin
			next_mask = enable_mask & ~wmask; // [RULE7]
		end else if (i_wr && hit(i_addr, `NIRQC_OFS_FAST_ENABLE)) begin
			next_fast_mask = fast_enable_mask | wmask;
			next_mask = enable_mask & ~wmask; // [RULE15]
		end else if (i_wr && hit(i_addr, `NIRQC_OFS_FAST_CLEAR)) begin
			next_fast_mask = fast_enable_mask & ~wmask;
		end
	end

	always @* begin
		next_rdata = `NIRQC_RESET_VALUE;
		if (i_rd) begin
			case (1'b1)
				hit(i_addr, `NIRQC_OFS_PENDING_STATUS): next_rdata = pending_status; // [RULE5] [RULE13]
				hit(i_addr, `NIRQC_OFS_SOURCE_LEVEL):   next_rdata = source_level;
				hit(i_addr, `NIRQC_OFS_ENABLE_MASK):    next_rdata = enable_mask; // [RULE6]
				hit(i_addr, `NIRQC_OFS_FAST_ENABLE):    next_rdata = fast_enable_mask;
				hit(i_addr, `NIRQC_OFS_SOFT_CONFIG):    next_rdata = {{(DATA_W-3){1'b0}}, soft_fast, soft_normal, 1'b0};
				default:                                next_rdata = `NIRQC_RESET_VALUE;
			endcase
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			enable_mask      <= `NIRQC_RESET_VALUE; // [RULE19]
			fast_enable_mask <= `NIRQC_RESET_VALUE;
			soft_normal      <= 1'b0;
			soft_fast        <= 1'b0;
			o_rdata          <= `NIRQC_RESET_VALUE;
			o_irq            <= 1'b0;
			o_fiq            <= 1'b0;
			o_wake           <= 1'b0;
		end else begin
			enable_mask      <= next_mask;
			fast_enable_mask <= next_fast_mask;
			if (i_wr && hit(i_addr, `NIRQC_OFS_SOFT_CONFIG)) begin
				soft_normal <= i_wdata[`NIRQC_BIT_SOFT]; // [RULE16]
				soft_fast   <= i_wdata[`NIRQC_BIT_SOFT+1];
			end
			o_rdata <= next_rdata;
			o_irq   <= |pending_status; // [RULE4]
			o_fiq   <= fast_or; // [RULE17]
			// no core-side masking input exists, so flags and wake stay live
			o_wake  <= (|pending_status) | fast_or; // [RULE14]
		end
	end
endmodule // nirqc_top

// file: normal_interrupt_request_controller_tb.sv
// bench of the normal request controller
// nirqc_top with default widths, 25 ns clock
`timescale 1ns/10ps
`include "nirqc_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module normal_interrupt_request_controller_tb;
	localparam PS = `NIRQC_OFS_PENDING_STATUS, SL = `NIRQC_OFS_SOURCE_LEVEL, EM = `NIRQC_OFS_ENABLE_MASK;
	localparam EC = `NIRQC_OFS_ENABLE_CLEAR, FE = `NIRQC_OFS_FAST_ENABLE, SC = `NIRQC_OFS_SOFT_CONFIG;
	logic        i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, o_irq, o_fiq, o_wake;
	logic [31:0] i_addr = 0, i_wdata = 0, o_rdata;
	logic [17:0] raise = 0, src;
	int          failures = 0, check_count = 0, i;
	always #12.5 i_sys_clk = ~i_sys_clk;
	nirqc_periph per_u (.i_sys_clk, .i_raise(raise), .o_src_req(src));
	nirqc_top dut_u (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_src_req(src), .o_irq,
		.o_fiq, .o_wake);
	task results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input logic [31:0] a, d);
		@(posedge i_sys_clk) begin i_addr <= a; i_wdata <= d; i_wr <= 1; end
		@(posedge i_sys_clk) i_wr <= 0;
	endtask
	task rd(input logic [31:0] a, e);
		@(posedge i_sys_clk) begin i_addr <= a; i_rd <= 1; end
		@(posedge i_sys_clk) i_rd <= 0;
		#1 `CHK("rdata", e, o_rdata)
	endtask
	// requests cross a synchroniser, so wait a bounded number of cycles
	task wt(input logic e, f);
		for (i = 0; i < 20 && {o_irq, o_fiq} !== {e, f}; i++) @(posedge i_sys_clk) #1;
		`CHK("irq fiq", {e, f}, {o_irq, o_fiq})
		`CHK("wake", e | f, o_wake)
		if (i == 20) results;
	endtask
	task t_reset;
		rd(PS, 0); rd(SL, 0); rd(EM, 0); wt(0, 0);
		$display("t_reset end");
	endtask
	task t_mask;
		wr(EM, '1); rd(EM, `NIRQC_MASKABLE);
		wr(EM, 0); rd(EM, `NIRQC_MASKABLE);
		wr(EC, 4); rd(EM, 32'h000f7ff8); rd(EC, 0);
		rd(32'hffff0200, 0);
		$display("t_mask end");
	endtask
	task t_src;
		@(posedge i_sys_clk) raise <= 18'h2003;
		wt(1, 0);
		rd(PS, 32'h8); rd(SL, 32'hc);
		wr(FE, 8); wt(0, 1); rd(PS, 0);
		rd(EM, 32'h000f7ff0); wr(EM, 8); wt(1, 0);
		@(posedge i_sys_clk) raise <= 0;
		wt(0, 0); rd(SL, 0);
		$display("t_src end");
	endtask
	task t_soft;
		wr(SC, 2); wt(1, 0); rd(SL, 2); rd(PS, 2);
		wr(EC, '1); rd(PS, 2); rd(EM, 0);
		wr(SC, 0); wt(0, 0);
		$display("t_soft end");
	endtask
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 0;
		t_reset;
		t_mask;
		t_src;
		t_soft;
		results;
	end
endmodule // normal_interrupt_request_controller_tb
